// file: hw/ncss_consts.svh
/*
 Constants of the network clock sync sender: field widths, positions,
 timing figures and reset values.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef NCSS_CONSTS_SVH
`define NCSS_CONSTS_SVH

// ------------------------------------------------------------
// Field widths of the broadcast word
// ------------------------------------------------------------
`define NCSS_SEC_W 6
`define NCSS_MIN_W 6
`define NCSS_HOUR_W 5
`define NCSS_DOW_W 3
`define NCSS_DAY_W 5
`define NCSS_MON_W 4
`define NCSS_YEAR_W 7
`define NCSS_STAMP_W 36

// ------------------------------------------------------------
// Field positions inside the broadcast word
// ------------------------------------------------------------
`define NCSS_POS_SEC 0
`define NCSS_POS_MIN 6
`define NCSS_POS_HOUR 12
`define NCSS_POS_DOW 17
`define NCSS_POS_DAY 20
`define NCSS_POS_MON 25
`define NCSS_POS_YEAR 29

// ------------------------------------------------------------
// Timing and reset values
// ------------------------------------------------------------
`define NCSS_MAX_SKEW_S 5
`define NCSS_SEC_ZERO 6'h00
`define NCSS_SEC_LAST 6'h3B
`define NCSS_STAMP_RST 36'h0_0000_0000

`endif

// file: hw/ncss_pkg.sv
/*
 Types of the network clock sync sender.
 Assumes ncss_consts.svh on the include path.
*/
`include "ncss_consts.svh"

package ncss_pkg;

   // Sender states
   typedef enum logic [1:0] {
      NCSS_IDLE = 2'b00,
      NCSS_ARMED = 2'b01,
      NCSS_SEND = 2'b10
   } ncss_state_e;

   typedef logic [`NCSS_STAMP_W-1:0] ncss_stamp_t;

endpackage

// file: hw/ncss_in_if.sv
/*
 Interface carrying the synchronised inputs from the input stage to
 the sender core.
 Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface ncss_in_if;
   logic enable;
   logic trigger;
   logic net_ok;
   logic [5:0] seconds;

   modport stage (output enable, output trigger, output net_ok,
      output seconds);
   modport core (input enable, input trigger, input net_ok,
      input seconds);
endinterface

`default_nettype wire

// file: hw/ncss_sync_stage.sv
/*
 Two-flop synchronisers for the pin-level inputs of the sender.
 Assumes asynchronous pins; one clock for all logic.
*/
`timescale 1ns/1ps
`default_nettype none

module ncss_sync_stage
   import ncss_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable_pin,
   input wire logic trigger_pin,
   input wire logic net_ok_pin,
   ncss_in_if.stage sync_out
);

   // ------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------
   logic [2:0] first;
   logic [2:0] second;
   logic [2:0] next_first;
   logic [2:0] next_second;

   // Next values: first stage takes pins, second takes first
   always_comb begin
      next_first = {net_ok_pin, trigger_pin, enable_pin};
      next_second = first;
   end

   // Registers of both stages
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         first <= 3'h0;
         second <= 3'h0;
      end else begin
         first <= next_first;
         second <= next_second;
      end
   end

   // Only the second stage is seen by the core
   assign sync_out.enable = second[0];
   assign sync_out.trigger = second[1];
   assign sync_out.net_ok = second[2];

endmodule

`default_nettype wire

// file: hw/ncss_sender.sv
/*
 Network clock sync sender: arms on a trigger rising edge and sends
 the real-time clock stamp once the seconds count wraps to zero.
 Assumes the RTC stamp comes from logic on the same clock and the
 network transmitter takes SEND_VALID as a one-cycle send request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ncss_consts.svh"

module ncss_sender
   import ncss_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic ENABLE,
   input wire logic TRIGGER,
   input wire logic NET_OK,
   input wire logic [`NCSS_STAMP_W-1:0] RTC_STAMP,
   output logic SEND_VALID,
   output logic [`NCSS_STAMP_W-1:0] SEND_STAMP,
   output logic ARMED,
   output logic TRIGGER_ECHO
);

   // ------------------------------------------------------------
   // Input stage
   // ------------------------------------------------------------
   ncss_in_if sync_bus ();

   ncss_sync_stage u_sync (
      .clk (CLK),
      .reset_n (RESET_N),
      .enable_pin (ENABLE),
      .trigger_pin (TRIGGER),
      .net_ok_pin (NET_OK),
      .sync_out (sync_bus.stage)
   );

   // Seconds field is same-clock logic, no synchroniser
   assign sync_bus.seconds =
      RTC_STAMP[`NCSS_POS_SEC +: `NCSS_SEC_W];

   // ------------------------------------------------------------
   // Edge and wrap detection
   // ------------------------------------------------------------
   logic trig_prev;
   logic [`NCSS_SEC_W-1:0] sec_prev;
   logic next_trig_prev;
   logic [`NCSS_SEC_W-1:0] next_sec_prev;
   logic trig_rise;
   logic sec_wrap;

   // Rising edge only counts while enabled
   always_comb begin
      next_trig_prev = sync_bus.trigger;
      next_sec_prev = sync_bus.seconds;
      trig_rise = sync_bus.trigger && !trig_prev
         && sync_bus.enable;
      sec_wrap = (sync_bus.seconds == `NCSS_SEC_ZERO)
         && (sec_prev == `NCSS_SEC_LAST);
   end

   // History registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         trig_prev <= 1'b0;
         sec_prev <= `NCSS_SEC_ZERO;
      end else begin
         trig_prev <= next_trig_prev;
         sec_prev <= next_sec_prev;
      end
   end

   // ------------------------------------------------------------
   // Sender state machine
   // ------------------------------------------------------------
   // One state machine, so one sender per station
   ncss_state_e state;
   ncss_state_e next_state;
   logic next_send_valid;
   logic [`NCSS_STAMP_W-1:0] next_send_stamp;
   logic next_armed;
   logic next_trigger_echo;

   // Arm on edge, fire on wrap, drop on disable or bad network
   always_comb begin
      next_state = state;
      next_send_valid = 1'b0;
      next_send_stamp = SEND_STAMP;
      next_trigger_echo = sync_bus.trigger
         && sync_bus.enable;
      if (!sync_bus.enable || !sync_bus.net_ok) begin
         next_state = NCSS_IDLE;
      end else begin
         case (state)
            NCSS_IDLE: begin
               if (trig_rise) begin
                  next_state = NCSS_ARMED;
               end
            end
            NCSS_ARMED: begin
               if (sec_wrap) begin
                  next_state = NCSS_SEND;
                  next_send_valid = 1'b1;
                  next_send_stamp = RTC_STAMP;
               end
            end
            NCSS_SEND: begin
               next_state = NCSS_IDLE;
            end
            default: begin
               next_state = NCSS_IDLE;
            end
         endcase
      end
      next_armed = (next_state == NCSS_ARMED);
   end

   // State and output registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= NCSS_IDLE;
         SEND_VALID <= 1'b0;
         SEND_STAMP <= `NCSS_STAMP_RST;
         ARMED <= 1'b0;
         TRIGGER_ECHO <= 1'b0;
      end else begin
         state <= next_state;
         SEND_VALID <= next_send_valid;
         SEND_STAMP <= next_send_stamp;
         ARMED <= next_armed;
         TRIGGER_ECHO <= next_trigger_echo;
      end
   end

endmodule

`default_nettype wire

// file: test/ncss_chk.sv
/*
 Assertions on the sender ports.
 Assumes one clock and binding to ncss_sender.
*/
`timescale 1ns/1ps
`default_nettype none
module ncss_chk
   import ncss_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic ENABLE,
   input wire logic TRIGGER,
   input wire logic NET_OK,
   input wire ncss_stamp_t RTC_STAMP,
   input wire logic SEND_VALID,
   input wire ncss_stamp_t SEND_STAMP,
   input wire logic ARMED
);
   // ----
   // Pin run lengths
   // ----
   logic [3:0] hi_n, en_n, next_hi_n, next_en_n;
   // Saturating counts of high samples
   always_comb begin
      next_hi_n = TRIGGER ? hi_n + 4'(hi_n != 4'hF) : 4'h0;
      next_en_n = ENABLE ? en_n + 4'(en_n != 4'hF) : 4'h0;
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hi_n <= 4'h0;
         en_n <= 4'h0;
      end else begin
         hi_n <= next_hi_n;
         en_n <= next_en_n;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   stamp_match_a: assert property (
      SEND_VALID |-> SEND_STAMP == $past(RTC_STAMP)) else $error("bad stamp");
   wrap_cause_a: assert property (SEND_VALID |-> $past(ARMED) &&
      $past(RTC_STAMP[5:0]) == 6'h00 && $past(RTC_STAMP[5:0], 2) == 6'h3B)
      else $error("send without wrap");
   prompt_send_a: assert property ((ENABLE && NET_OK)[*3] ##0
      (ARMED && RTC_STAMP[5:0] == 6'h00 && $past(RTC_STAMP[5:0]) == 6'h3B)
      |=> SEND_VALID) else $error("late send");
   one_pulse_a: assert property (
      SEND_VALID |=> !SEND_VALID && !ARMED) else $error("long send");
   off_quiet_a: assert property (
      !ENABLE[*4] |-> !ARMED && !SEND_VALID) else $error("active off");
   net_down_a: assert property (
      !NET_OK[*4] |-> !ARMED && !SEND_VALID) else $error("active net down");
   held_high_a: assert property (
      $rose(ARMED) |-> hi_n < 4'h8) else $error("held trigger armed");
   stale_edge_a: assert property (
      $rose(ARMED) |-> en_n >= hi_n) else $error("stale edge armed");
   cover property (SEND_VALID);
   cover property ($rose(ARMED));
   cover property (ARMED ##1 !ARMED && !SEND_VALID);
endmodule
bind ncss_sender ncss_chk chk (.CLK, .RESET_N, .ENABLE, .TRIGGER, .NET_OK,
   .RTC_STAMP, .SEND_VALID, .SEND_STAMP, .ARMED);
`default_nettype wire

// file: test/ncss_peer_station.sv
/*
 Receiving station clock model.
 Assumes a one-cycle send request.
*/
`timescale 1ns/1ps
`default_nettype none
module ncss_peer_station
   import ncss_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic send_valid,
   input wire ncss_stamp_t send_stamp,
   output var ncss_stamp_t peer_rtc
);
   // ----
   // Local clock
   // ----
   ncss_stamp_t next_peer_rtc;
   // Overwrite own clock with the broadcast
   always_comb begin
      next_peer_rtc = send_valid ? send_stamp : peer_rtc;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         peer_rtc <= 36'h0;
      end else begin
         peer_rtc <= next_peer_rtc;
      end
   end
endmodule
`default_nettype wire

// file: test/network_clock_sync_sender_tb.sv
/*
 Bench of the sender with one peer station.
 Assumes 100 MHz; inputs change 1 ns after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module network_clock_sync_sender_tb;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic ENABLE = 1'b0;
   logic TRIGGER = 1'b0;
   logic NET_OK = 1'b0;
   logic [35:0] RTC_STAMP = 36'h1E;
   logic SEND_VALID, ARMED, TRIGGER_ECHO;
   logic [35:0] SEND_STAMP, peer_rtc, got;
   logic [29:0] up = 30'h2345_6789;
   logic [2:0] rows [5] = '{3'h7, 3'h2, 3'h4, 3'h0, 3'h7};
   int bad_count = 0;
   int compares = 0;
   int sends = 0;
   int n0;
   // ----
   // Clock, design, peer
   // ----
   always #5 CLK = ~CLK;
   // Single sender instance in the bench
   ncss_sender uut (.CLK, .RESET_N, .ENABLE, .TRIGGER, .NET_OK, .RTC_STAMP,
      .SEND_VALID, .SEND_STAMP, .ARMED, .TRIGGER_ECHO);
   ncss_peer_station peer (.clk(CLK), .reset_n(RESET_N),
      .send_valid(SEND_VALID), .send_stamp(SEND_STAMP), .peer_rtc);
   // Count send pulses once settled
   always @(negedge CLK) begin
      if (SEND_VALID === 1'b1) begin
         sends++;
         got = SEND_STAMP;
      end
   end
   task automatic chk(input string what, input logic [35:0] e, s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic arm(input logic en, input logic net);
      ENABLE = en;
      NET_OK = net;
      TRIGGER = 1'b0;
      tick(4);
      TRIGGER = 1'b1;
      tick(6);
   endtask
   // Seconds pass 59 then 0
   task automatic roll(input logic e);
      n0 = sends;
      RTC_STAMP = {up, 6'h3B};
      tick(1);
      RTC_STAMP = {up, 6'h00};
      tick(4);
      RTC_STAMP = {up, 6'h1E};
      chk("sends", 36'(e), 36'(sends - n0));
      chk("armed", 36'h0, 36'(ARMED));
      if (e) begin
         chk("stamp", {up, 6'h00}, got);
         chk("peer", {up, 6'h00}, peer_rtc);
      end
      $display("test done");
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (3000) @(posedge CLK);
      bad_count++;
      close_out;
   end
   // Reset, table rows, then edge cases
   initial begin
      tick(4);
      chk("reset", 36'h0, 36'({SEND_VALID, ARMED, TRIGGER_ECHO}));
      chk("reset stamp", 36'h0, SEND_STAMP);
      RESET_N = 1'b1;
      foreach (rows[i]) begin
         up = up + 30'h1;
         arm(rows[i][2], rows[i][1]);
         chk("armed", 36'(rows[i][0]), 36'(ARMED));
         chk("echo", 36'(rows[i][2]), 36'(TRIGGER_ECHO));
         roll(rows[i][0]);
      end
      roll(1'b0);
      ENABLE = 1'b0;
      TRIGGER = 1'b0;
      tick(4);
      TRIGGER = 1'b1;
      tick(4);
      ENABLE = 1'b1;
      tick(6);
      roll(1'b0);
      arm(1'b1, 1'b1);
      NET_OK = 1'b0;
      tick(5);
      NET_OK = 1'b1;
      tick(4);
      roll(1'b0);
      // Reset in mid-run drops an armed request
      arm(1'b1, 1'b1);
      chk("armed before reset", 36'h1, 36'(ARMED));
      RESET_N = 1'b0;
      TRIGGER = 1'b0;
      tick(2);
      chk("reset armed", 36'h0, 36'(ARMED));
      RESET_N = 1'b1;
      tick(4);
      roll(1'b0);
      close_out;
   end
endmodule
`default_nettype wire
